// ---- shared/rfte_pkg.sv ----
// Constants shared by the receive filter and transmit enable control block
package rfte_pkg;
	// Bus geometry
	localparam int          ADDR_W          = 16;
	localparam int          DATA_W          = 32;
	localparam int          SEL_W           = 4;
	// Register byte addresses
	localparam logic [15:0] ADDR_TX_CTRL    = 16'h0400;
	localparam logic [15:0] ADDR_TX_STATUS  = 16'h0408;
	localparam logic [15:0] ADDR_RX_FILTER  = 16'h5008;
	// Reset values
	localparam logic [31:0] TX_CTRL_RST     = 32'h0000_0000;
	localparam logic [15:0] RX_FILTER_RST   = 16'h0000;
	// Transmit control fields
	localparam int          TXC_EN_BIT      = 1;
	// Receive filter control fields
	localparam int          RXF_STORE_W     = 16;
	localparam int          RXF_ISCSI_OFF   = 0;
	localparam int          RXF_WC_LO       = 1;
	localparam int          RXF_WC_HI       = 5;
	localparam int          RXF_NFSW_OFF    = 6;
	localparam int          RXF_NFSR_OFF    = 7;
	localparam int          RXF_VER_LO      = 8;
	localparam int          RXF_VER_HI      = 9;
	localparam int          RXF_V6_FILT_OFF = 10;
	localparam int          RXF_V6_CSUM_OFF = 11;
	localparam int          RXF_ACK_INT_OFF = 12;
	localparam int          RXF_ACK_PAY_OFF = 13;
	localparam int          RXF_FRAG_OFF    = 14;
	localparam int          RXF_EXT_STAT_ON = 15;
	// File protocol version codes
	localparam logic [1:0]  FILE_PROTOCOL_VERSION_2       = 2'h0;
	localparam logic [1:0]  FILE_PROTOCOL_VERSION_3       = 2'h1;
	localparam logic [1:0]  FILE_PROTOCOL_VERSION_4       = 2'h2;
	localparam logic [1:0]  FILE_PROTOCOL_VERSION_RSVD    = 2'h3;
	// Transmit status fields
	localparam int          TXS_FRAME_BIT   = 0;
	localparam int          TXS_QUEUED_BIT  = 1;
	localparam int          TXS_OUT_BIT     = 2;
	// Transmit FIFO shape
	localparam int          FIFO_DEPTH      = 32;
	localparam int          FIFO_W          = 33;

	typedef enum logic {
		TX_IDLE,
		TX_FRAME
	} rfte_tx_state_t;
endpackage

// ---- verilog/rfte_fifo.sv ----
// Transmit FIFO with registered read data and registered input ready
module rfte_fifo #(
	parameter int WIDTH = 33,
	parameter int DEPTH = 32
) (
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	input  wire logic [WIDTH-1:0] in_data_i,
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	output logic      [WIDTH-1:0] out_data_o,
	output logic                  out_valid_o,
	input  wire logic             out_ready_i
);
	localparam int PW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [PW-1:0]    wr_ptr_reg;
	logic [PW-1:0]    rd_ptr_reg;
	logic [PW:0]      count_reg;
	logic [PW:0]      count_next;
	logic             in_ready_reg;
	logic             out_valid_reg;
	logic [WIDTH-1:0] out_data_reg;
	logic             push;
	logic             load;

	// Memory words move to the output register when it is empty or being drained
	assign push = in_valid_i & in_ready_reg;
	assign load = (count_reg != '0) & (~out_valid_reg | out_ready_i);
	assign count_next = count_reg + {{PW{1'b0}}, push} - {{PW{1'b0}}, load};

	// Storage array, no reset needed
	always_ff @(posedge clk_i) begin
		if (push) begin
			mem_reg[wr_ptr_reg] <= in_data_i;
		end
	end

	// Pointers, occupancy and a registered ready so the source sees no long path
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wr_ptr_reg   <= '0;
			rd_ptr_reg   <= '0;
			count_reg    <= '0;
			in_ready_reg <= 1'b0;
		end else begin
			wr_ptr_reg   <= wr_ptr_reg + PW'(push);
			rd_ptr_reg   <= rd_ptr_reg + PW'(load);
			count_reg    <= count_next;
			in_ready_reg <= count_next < (PW+1)'(DEPTH);
		end
	end

	// Output register holds one more word beyond the array
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			out_valid_reg <= 1'b0;
			out_data_reg  <= '0;
		end else if (load) begin
			out_valid_reg <= 1'b1;
			out_data_reg  <= mem_reg[rd_ptr_reg];
		end else if (out_ready_i) begin
			out_valid_reg <= 1'b0;
		end
	end

	assign in_ready_o  = in_ready_reg;
	assign out_valid_o = out_valid_reg;
	assign out_data_o  = out_data_reg;
endmodule

// ---- verilog/rfte_ctrl.sv ----
// Receive filter control and transmit enable control with Wishbone registers
// What this block does
// RL1 - Storage-target filter-off bit stops iSCSI recognition
// RL2 - Bits 5:1 give iSCSI header word count
// RL3 - Bit 6 stops file write header recognition
// RL4 - Bit 7 stops file read header recognition
// RL5 - Bits 9:8 select file protocol version
// RL6 - Bit 10 disables next-gen IP filtering
// RL7 - Bit 11 disables next-gen IP checksum
// RL8 - Bit 12 stops accelerated ACK interrupt
// RL9 - Bit 13 relaxes ACK classification to flag
// RL10 - Bit 14 stops header split on fragments
// RL11 - Extended status when bit 15 or split
// RL12 - Unparsed file packet counts as iSCSI; the block does this only for bits 6/7, not for a reserved version
// RL13 - Software writes zero to bits 31:16
// RL14 - Transmit enable bit 1 enables transmitter
// RL15 - Clearing enable finishes current packet, then stops
// RL16 - Queued FIFO data kept, resumes on enable
// RL17 - Software adds reset to flush FIFO
// RL18 - Bit 2 reads zero; write zeros
module rfte_ctrl
	import rfte_pkg::*;
(
	input  wire logic              clk_i,
	input  wire logic              rst_i,
	// Wishbone classic slave
	input  wire logic              wb_cyc_i,
	input  wire logic              wb_stb_i,
	input  wire logic              wb_we_i,
	input  wire logic [ADDR_W-1:0] wb_adr_i,
	input  wire logic [SEL_W-1:0]  wb_sel_i,
	input  wire logic [DATA_W-1:0] wb_dat_i,
	output logic      [DATA_W-1:0] wb_dat_o,
	output logic                   wb_ack_o,
	// Receive packet facts from the parser, one pulse per packet
	input  wire logic              rx_pkt_valid_i,
	input  wire logic              rx_is_iscsi_i,
	input  wire logic              rx_is_nfs_write_i,
	input  wire logic              rx_is_nfs_read_i,
	input  wire logic              rx_is_ipv6_i,
	input  wire logic              rx_tcp_ack_flag_i,
	input  wire logic              rx_tcp_no_payload_i,
	input  wire logic              rx_is_ip_frag_i,
	input  wire logic              rx_split_desc_i,
	// Receive decisions
	output logic                   rx_result_valid_o,
	output logic                   rx_iscsi_match_o,
	output logic      [4:0]        rx_hdr_words_o,
	output logic                   rx_nfs_write_match_o,
	output logic                   rx_nfs_read_match_o,
	output logic      [1:0]        rx_nfs_version_o,
	output logic                   rx_ipv6_filter_o,
	output logic                   rx_csum_en_o,
	output logic                   rx_ack_o,
	output logic                   rx_ack_int_o,
	output logic                   rx_hdr_split_o,
	output logic                   rx_ext_status_o,
	// Transmit stream into the FIFO
	input  wire logic [DATA_W-1:0] tx_in_data_i,
	input  wire logic              tx_in_last_i,
	input  wire logic              tx_in_valid_i,
	output logic                   tx_in_ready_o,
	// Transmit stream toward the MAC
	output logic      [DATA_W-1:0] tx_out_data_o,
	output logic                   tx_out_last_o,
	output logic                   tx_out_valid_o,
	input  wire logic              tx_out_ready_i
);
	logic                   tx_en_reg;
	logic [RXF_STORE_W-1:0] rx_filt_reg;
	logic                   ack_reg;
	logic [DATA_W-1:0]      rdata_reg;
	logic [DATA_W-1:0]      rdata_next;
	logic                   wb_req;
	logic                   wb_wr;
	logic [DATA_W-1:0]      wmask;
	rfte_tx_state_t         tx_state_reg;
	logic                   out_valid_reg;
	logic [DATA_W-1:0]      out_data_reg;
	logic                   out_last_reg;
	logic                   fifo_ready;
	logic [FIFO_W-1:0]      fifo_out;
	logic                   fifo_valid;
	logic                   tx_gate;
	logic                   tx_pop;

	// A request is served once; ack drops in the next cycle so cycles stay apart
	assign wb_req = wb_cyc_i & wb_stb_i & ~ack_reg;
	// Writes land at the edge where the master sees ack, while it still holds the request
	assign wb_wr  = wb_cyc_i & wb_stb_i & wb_we_i & ack_reg;

	// Byte enables become a bit mask for writes
	genvar gi;
	for (gi = 0; gi < SEL_W; gi++) begin : g_mask
		assign wmask[gi*8 +: 8] = {8{wb_sel_i[gi]}};
	end

	// Bus acknowledge, one cycle after the request is seen
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_reg <= 1'b0;
		end else begin
			ack_reg <= wb_req;
		end
	end

	// Transmit enable; only bit 1 is storage, neighbours stay zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tx_en_reg <= TX_CTRL_RST[TXC_EN_BIT];
		end else if (wb_wr & (wb_adr_i == ADDR_TX_CTRL) & wmask[TXC_EN_BIT]) begin
			tx_en_reg <= wb_dat_i[TXC_EN_BIT]; // [RL14]
		end
	end

	// Receive filter control; the upper half is not stored, so it reads zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rx_filt_reg <= RX_FILTER_RST;
		end else if (wb_wr & (wb_adr_i == ADDR_RX_FILTER)) begin
			rx_filt_reg <= (rx_filt_reg & ~wmask[RXF_STORE_W-1:0])
				| (wb_dat_i[RXF_STORE_W-1:0] & wmask[RXF_STORE_W-1:0]);
		end
	end

	// Read mux; unmapped addresses answer with zero data
	always_comb begin
		rdata_next = '0;
		unique case (wb_adr_i)
			ADDR_TX_CTRL: begin
				rdata_next[TXC_EN_BIT] = tx_en_reg; // [RL18]
			end
			ADDR_TX_STATUS: begin
				rdata_next[TXS_FRAME_BIT]  = (tx_state_reg == TX_FRAME);
				rdata_next[TXS_QUEUED_BIT] = fifo_valid;
				rdata_next[TXS_OUT_BIT]    = out_valid_reg;
			end
			ADDR_RX_FILTER: begin
				rdata_next[RXF_STORE_W-1:0] = rx_filt_reg;
			end
			default: begin
				rdata_next = '0;
			end
		endcase
	end

	// Read data register; cleared outside reads so the bus is quiet
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rdata_reg <= '0;
		end else if (wb_req & ~wb_we_i) begin
			rdata_reg <= rdata_next;
		end else begin
			rdata_reg <= '0;
		end
	end

	assign wb_ack_o = ack_reg;
	assign wb_dat_o = rdata_reg;

	// Receive decisions, registered one cycle after the packet pulse
	logic       iscsi_off;
	logic       ver_ok;
	logic       nfs_w_hit;
	logic       nfs_r_hit;
	logic       nfs_as_iscsi;
	logic       ack_hit;
	assign iscsi_off = rx_filt_reg[RXF_ISCSI_OFF];
	// A reserved version leaves file headers unparsed
	assign ver_ok    = rx_filt_reg[RXF_VER_HI:RXF_VER_LO] != FILE_PROTOCOL_VERSION_RSVD; // [RL5]
	assign nfs_w_hit = rx_is_nfs_write_i & ~rx_filt_reg[RXF_NFSW_OFF] & ver_ok; // [RL3]
	assign nfs_r_hit = rx_is_nfs_read_i & ~rx_filt_reg[RXF_NFSR_OFF] & ver_ok; // [RL4]
	// File packets whose parsing is off fall back to storage-target recognition
	assign nfs_as_iscsi = (rx_is_nfs_write_i & rx_filt_reg[RXF_NFSW_OFF])
		| (rx_is_nfs_read_i & rx_filt_reg[RXF_NFSR_OFF]); // [RL12]
	assign ack_hit = rx_tcp_ack_flag_i
		& (rx_filt_reg[RXF_ACK_PAY_OFF] | rx_tcp_no_payload_i); // [RL9]

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rx_result_valid_o <= 1'b0;
		end else begin
			rx_result_valid_o <= rx_pkt_valid_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rx_iscsi_match_o     <= 1'b0;
			rx_hdr_words_o       <= '0;
			rx_nfs_write_match_o <= 1'b0;
			rx_nfs_read_match_o  <= 1'b0;
			rx_nfs_version_o     <= FILE_PROTOCOL_VERSION_2;
			rx_ipv6_filter_o     <= 1'b0;
			rx_csum_en_o         <= 1'b0;
			rx_ack_o             <= 1'b0;
			rx_ack_int_o         <= 1'b0;
			rx_hdr_split_o       <= 1'b0;
			rx_ext_status_o      <= 1'b0;
		end else if (rx_pkt_valid_i) begin
			rx_iscsi_match_o     <= ~iscsi_off & (rx_is_iscsi_i | nfs_as_iscsi); // [RL1] [RL12]
			rx_hdr_words_o       <= rx_filt_reg[RXF_WC_HI:RXF_WC_LO]; // [RL2]
			rx_nfs_write_match_o <= nfs_w_hit; // [RL3]
			rx_nfs_read_match_o  <= nfs_r_hit; // [RL4]
			rx_nfs_version_o     <= rx_filt_reg[RXF_VER_HI:RXF_VER_LO]; // [RL5]
			rx_ipv6_filter_o     <= rx_is_ipv6_i & ~rx_filt_reg[RXF_V6_FILT_OFF]; // [RL6]
			rx_csum_en_o         <= ~(rx_is_ipv6_i & rx_filt_reg[RXF_V6_CSUM_OFF]); // [RL7]
			rx_ack_o             <= ack_hit; // [RL9]
			rx_ack_int_o         <= ack_hit & ~rx_filt_reg[RXF_ACK_INT_OFF]; // [RL8]
			rx_hdr_split_o       <= rx_split_desc_i
				& ~(rx_is_ip_frag_i & rx_filt_reg[RXF_FRAG_OFF]); // [RL10]
			rx_ext_status_o      <= rx_filt_reg[RXF_EXT_STAT_ON] | rx_split_desc_i; // [RL11]
		end
	end

	// Transmit FIFO; only reset empties it, disabling merely holds it
	rfte_fifo #(
		.WIDTH (FIFO_W),
		.DEPTH (FIFO_DEPTH)
	) i_rfte_fifo (
		.clk_i       (clk_i),
		.rst_i       (rst_i),
		.in_data_i   ({tx_in_last_i, tx_in_data_i}),
		.in_valid_i  (tx_in_valid_i),
		.in_ready_o  (fifo_ready),
		.out_data_o  (fifo_out),
		.out_valid_o (fifo_valid),
		.out_ready_i (tx_pop)
	);
	assign tx_in_ready_o = fifo_ready;

	// Words leave while enabled, or while a started packet is unfinished
	assign tx_gate = tx_en_reg | (tx_state_reg == TX_FRAME); // [RL14] [RL15]
	assign tx_pop  = tx_gate & (~out_valid_reg | tx_out_ready_i); // [RL16]

	// Packet tracker; a frame ends only with its last word
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tx_state_reg <= TX_IDLE;
		end else begin
			unique case (tx_state_reg)
				TX_IDLE: begin
					if (tx_pop & fifo_valid & ~fifo_out[DATA_W]) begin
						tx_state_reg <= TX_FRAME;
					end
				end
				TX_FRAME: begin
					if (tx_pop & fifo_valid & fifo_out[DATA_W]) begin
						tx_state_reg <= TX_IDLE; // [RL15]
					end
				end
			endcase
		end
	end

	// Output stage register toward the MAC
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			out_valid_reg <= 1'b0;
			out_data_reg  <= '0;
			out_last_reg  <= 1'b0;
		end else if (tx_pop & fifo_valid) begin
			out_valid_reg <= 1'b1;
			out_data_reg  <= fifo_out[DATA_W-1:0];
			out_last_reg  <= fifo_out[DATA_W];
		end else if (tx_out_ready_i) begin
			out_valid_reg <= 1'b0;
		end
	end

	assign tx_out_valid_o = out_valid_reg;
	assign tx_out_data_o  = out_data_reg;
	assign tx_out_last_o  = out_last_reg;

	// Checks on the receive decisions
	chk_iscsi_off_kills: assert property (@(posedge clk_i) disable iff (rst_i) // [RL1]
		rx_pkt_valid_i & iscsi_off |=> rx_result_valid_o & ~rx_iscsi_match_o)
		else $error("storage target match while disabled");
	chk_word_count_out: assert property (@(posedge clk_i) disable iff (rst_i) // [RL2]
		rx_pkt_valid_i |=> rx_hdr_words_o == $past(rx_filt_reg[RXF_WC_HI:RXF_WC_LO]))
		else $error("header word count mismatch");
	chk_nfs_write_off: assert property (@(posedge clk_i) disable iff (rst_i) // [RL3]
		rx_pkt_valid_i & rx_filt_reg[RXF_NFSW_OFF] |=> ~rx_nfs_write_match_o)
		else $error("file write match while disabled");
	chk_nfs_read_off: assert property (@(posedge clk_i) disable iff (rst_i) // [RL4]
		rx_pkt_valid_i & rx_filt_reg[RXF_NFSR_OFF] |=> ~rx_nfs_read_match_o)
		else $error("file read match while disabled");
	chk_ipv6_csum_off: assert property (@(posedge clk_i) disable iff (rst_i) // [RL7]
		rx_pkt_valid_i & rx_is_ipv6_i & rx_filt_reg[RXF_V6_CSUM_OFF] |=> ~rx_csum_en_o)
		else $error("checksum on next-gen packet while disabled");
	chk_ack_int_off: assert property (@(posedge clk_i) disable iff (rst_i) // [RL8]
		rx_pkt_valid_i & rx_filt_reg[RXF_ACK_INT_OFF] |=> ~rx_ack_int_o)
		else $error("accelerated ack interrupt while disabled");
	chk_ack_needs_empty: assert property (@(posedge clk_i) disable iff (rst_i) // [RL9]
		rx_pkt_valid_i & rx_tcp_ack_flag_i & ~rx_tcp_no_payload_i
		& ~rx_filt_reg[RXF_ACK_PAY_OFF] |=> ~rx_ack_o)
		else $error("ack with payload classified as ack");
	chk_frag_no_split: assert property (@(posedge clk_i) disable iff (rst_i) // [RL10]
		rx_pkt_valid_i & rx_is_ip_frag_i & rx_filt_reg[RXF_FRAG_OFF] |=> ~rx_hdr_split_o)
		else $error("fragment was split");
	chk_ext_status_on: assert property (@(posedge clk_i) disable iff (rst_i) // [RL11]
		rx_pkt_valid_i & (rx_filt_reg[RXF_EXT_STAT_ON] | rx_split_desc_i) |=> rx_ext_status_o)
		else $error("extended status missing");
	// Checks on transmit gating and register reads
	chk_tx_start_gate: assert property (@(posedge clk_i) disable iff (rst_i) // [RL14]
		$rose(tx_out_valid_o) |-> $past(tx_en_reg) | $past(tx_state_reg == TX_FRAME))
		else $error("word sent while transmitter disabled");
	chk_tx_hold_fifo: assert property (@(posedge clk_i) disable iff (rst_i) // [RL16]
		~tx_en_reg & (tx_state_reg == TX_IDLE) & fifo_valid |=> fifo_valid)
		else $error("queued data lost while disabled");
	chk_transmit_control_reserved: assert property (@(posedge clk_i) disable iff (rst_i) // [RL18]
		wb_req & ~wb_we_i & (wb_adr_i == ADDR_TX_CTRL) |=> wb_ack_o & (wb_dat_o[2:0] == {1'b0,
		$past(tx_en_reg), 1'b0}))
		else $error("transmit control reserved bits not zero");
endmodule

// ---- tb/rfte_ctrl_test.sv ----
// Self-checking bench for the receive filter and transmit enable control block
module rfte_ctrl_test import rfte_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;

	logic              clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
	logic [ADDR_W-1:0] wb_adr_i;
	logic [SEL_W-1:0]  wb_sel_i;
	logic [DATA_W-1:0] wb_dat_i, wb_dat_o, tx_in_data_i, tx_out_data_o;
	logic              rx_pkt_valid_i, rx_is_iscsi_i, rx_is_nfs_write_i, rx_is_nfs_read_i;
	logic              rx_is_ipv6_i, rx_tcp_ack_flag_i, rx_tcp_no_payload_i, rx_is_ip_frag_i;
	logic              rx_split_desc_i, rx_result_valid_o, rx_iscsi_match_o;
	logic [4:0]        rx_hdr_words_o;
	logic [1:0]        rx_nfs_version_o;
	logic              rx_nfs_write_match_o, rx_nfs_read_match_o, rx_ipv6_filter_o;
	logic              rx_csum_en_o, rx_ack_o, rx_ack_int_o, rx_hdr_split_o, rx_ext_status_o;
	logic              tx_in_last_i, tx_in_valid_i, tx_in_ready_o;
	logic              tx_out_last_o, tx_out_valid_o, tx_out_ready_i;
	logic [31:0]       seed = 32'hcc7b9329;
	logic [31:0]       rd_q[$];
	logic [15:0]       rx_q[$];
	logic [32:0]       tx_q[$];
	int                failures = 0, cmp_count = 0, out_count = 0, cycles = 0;

	rfte_ctrl i_rfte_ctrl (
		.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rx_pkt_valid_i(rx_pkt_valid_i),
		.rx_is_iscsi_i(rx_is_iscsi_i), .rx_is_nfs_write_i(rx_is_nfs_write_i),
		.rx_is_nfs_read_i(rx_is_nfs_read_i), .rx_is_ipv6_i(rx_is_ipv6_i),
		.rx_tcp_ack_flag_i(rx_tcp_ack_flag_i), .rx_tcp_no_payload_i(rx_tcp_no_payload_i),
		.rx_is_ip_frag_i(rx_is_ip_frag_i), .rx_split_desc_i(rx_split_desc_i),
		.rx_result_valid_o(rx_result_valid_o), .rx_iscsi_match_o(rx_iscsi_match_o),
		.rx_hdr_words_o(rx_hdr_words_o), .rx_nfs_write_match_o(rx_nfs_write_match_o),
		.rx_nfs_read_match_o(rx_nfs_read_match_o), .rx_nfs_version_o(rx_nfs_version_o),
		.rx_ipv6_filter_o(rx_ipv6_filter_o), .rx_csum_en_o(rx_csum_en_o), .rx_ack_o(rx_ack_o),
		.rx_ack_int_o(rx_ack_int_o), .rx_hdr_split_o(rx_hdr_split_o),
		.rx_ext_status_o(rx_ext_status_o), .tx_in_data_i(tx_in_data_i),
		.tx_in_last_i(tx_in_last_i), .tx_in_valid_i(tx_in_valid_i),
		.tx_in_ready_o(tx_in_ready_o), .tx_out_data_o(tx_out_data_o),
		.tx_out_last_o(tx_out_last_o), .tx_out_valid_o(tx_out_valid_o),
		.tx_out_ready_i(tx_out_ready_i)
	);

	// Clock at 20 MHz
	initial begin
		clk_i = 1'b0;
		forever #25 clk_i = ~clk_i;
	end

	// Xorshift source, fixed start so every run repeats
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	// Expected decision vector from filter settings and packet facts
	function automatic logic [15:0] rx_expect(input logic [15:0] f, input logic [7:0] p);
		logic ack;
		logic nv;
		ack = p[4] & (f[13] | p[5]);
		nv  = f[9:8] != FILE_PROTOCOL_VERSION_RSVD;
		return {~f[0] & (p[0] | (p[1] & f[6]) | (p[2] & f[7])), f[5:1],
			p[1] & ~f[6] & nv, p[2] & ~f[7] & nv, f[9:8], p[3] & ~f[10],
			~(p[3] & f[11]), ack, ack & ~f[12], p[7] & ~(p[6] & f[14]), f[15] | p[7]};
	endfunction

	// One compare task per kind of result
	task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic cmp_rx(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic cmp_tx(input logic [32:0] got, input logic [32:0] exp);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic lost(input logic [32:0] got);
		failures++;
		$display("Error at %0t: got %h expected %h", $time, got, 33'h0);
	endtask

	task automatic tally_and_finish;
		$display("Comparisons %0d, mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic end_test(input string name);
		$display("Test %s finished at %0t", name, $time);
	endtask

	// Classic single cycle; holds everything until ack is seen, then one idle edge
	task automatic wb_cycle(input logic [15:0] a, input logic we, input logic [31:0] d,
		input logic [3:0] s);
		{wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, we};
		wb_adr_i <= a;
		wb_sel_i <= s;
		wb_dat_i <= d;
		do @(posedge clk_i); while (wb_ack_o !== 1'b1);
		{wb_cyc_i, wb_stb_i} <= 2'b00;
		@(posedge clk_i);
	endtask

	task automatic wb_write(input logic [15:0] a, input logic [31:0] d, input logic [3:0] s);
		wb_cycle(a, 1'b1, d, s);
	endtask

	task automatic wb_read(input logic [15:0] a, input logic [31:0] exp);
		rd_q.push_back(exp);
		wb_cycle(a, 1'b0, 32'(rnd()), 4'hf);
	endtask

	// Offer one word and note it once the FIFO takes it
	task automatic push_tx(input logic [31:0] d, input logic l);
		tx_in_valid_i <= 1'b1;
		tx_in_data_i  <= d;
		tx_in_last_i  <= l;
		do @(posedge clk_i); while (tx_in_ready_o !== 1'b1);
		tx_q.push_back({l, d});
	endtask

	// Sink stalls about a quarter of the time
	always @(posedge clk_i) tx_out_ready_i <= (rnd() % 4) != 0;

	// Cut a hang short; the whole run needs a few hundred cycles
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			$display("Error at %0t: got %h expected %h", $time, cycles, 0);
			tally_and_finish();
		end
	end

	// Watcher: oldest note against each result as it appears
	always @(posedge clk_i) begin
		if (!rst_i) begin
			if (wb_ack_o && !wb_we_i) begin
				if (rd_q.size() == 0) lost(33'(wb_dat_o));
				else cmp_word(wb_dat_o, rd_q.pop_front());
			end
			if (rx_result_valid_o) begin
				if (rx_q.size() == 0) lost(33'h1);
				else cmp_rx({rx_iscsi_match_o, rx_hdr_words_o, rx_nfs_write_match_o,
					rx_nfs_read_match_o, rx_nfs_version_o, rx_ipv6_filter_o,
					rx_csum_en_o, rx_ack_o, rx_ack_int_o, rx_hdr_split_o,
					rx_ext_status_o}, rx_q.pop_front());
			end
			if (tx_out_valid_o && tx_out_ready_i) begin
				out_count++;
				if (tx_q.size() == 0) lost({tx_out_last_o, tx_out_data_o});
				else cmp_tx({tx_out_last_o, tx_out_data_o}, tx_q.pop_front());
			end
		end
	end

	// Main sequence
	initial begin
		int          base;
		int          n;
		logic [15:0] filt;
		logic [7:0]  p;
		rst_i <= 1'b1;
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} <= '0;
		{rx_pkt_valid_i, rx_is_iscsi_i, rx_is_nfs_write_i, rx_is_nfs_read_i} <= '0;
		{rx_is_ipv6_i, rx_tcp_ack_flag_i, rx_tcp_no_payload_i, rx_is_ip_frag_i} <= '0;
		{rx_split_desc_i, tx_in_data_i, tx_in_last_i, tx_in_valid_i} <= '0;
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		// Reset values, reserved bits, byte lanes, unmapped place
		wb_read(ADDR_TX_CTRL, 32'h0);
		wb_read(ADDR_RX_FILTER, 32'h0);
		wb_read(ADDR_TX_STATUS, 32'h0);
		wb_write(ADDR_TX_CTRL, 32'hffffffff, 4'hf);
		wb_read(ADDR_TX_CTRL, 32'h00000002);
		wb_write(ADDR_RX_FILTER, 32'hffffffff, 4'hf);
		wb_read(ADDR_RX_FILTER, 32'h0000ffff);
		wb_write(ADDR_RX_FILTER, 32'h0, 4'h2);
		wb_read(ADDR_RX_FILTER, 32'h000000ff);
		wb_write(16'h1234, 32'hffffffff, 4'hf);
		wb_read(16'h1234, 32'h0);
		wb_write(ADDR_TX_CTRL, 32'h0, 4'hf);
		end_test("registers");
		// Back-to-back packets under eight filter settings, every version code
		for (int i = 0; i < 64; i++) begin
			if (i % 8 == 0) begin
				rx_pkt_valid_i <= 1'b0;
				filt = 16'(rnd());
				filt[9:8] = 2'(i / 8 % 4);
				wb_write(ADDR_RX_FILTER, {16'h0, filt}, 4'hf);
			end
			p = 8'(rnd());
			rx_pkt_valid_i <= 1'b1;
			{rx_split_desc_i, rx_is_ip_frag_i, rx_tcp_no_payload_i, rx_tcp_ack_flag_i,
				rx_is_ipv6_i, rx_is_nfs_read_i, rx_is_nfs_write_i, rx_is_iscsi_i} <= p;
			rx_q.push_back(rx_expect(filt, p));
			@(posedge clk_i);
		end
		rx_pkt_valid_i <= 1'b0;
		end_test("receive filter");
		// Disable while the first packet is under way: it finishes, the next waits
		wb_write(ADDR_TX_CTRL, 32'h2, 4'hf);
		base = out_count;
		fork
			for (int k = 0; k < 15; k++) push_tx(32'(rnd()), k == 11 || k == 14);
			begin
				wait (out_count > base);
				wb_write(ADDR_TX_CTRL, 32'h0, 4'hf);
			end
		join
		tx_in_valid_i <= 1'b0;
		repeat (40) @(posedge clk_i);
		cmp_word(32'(out_count - base), 32'd12);
		wb_read(ADDR_TX_STATUS, 32'h00000002);
		wb_write(ADDR_TX_CTRL, 32'h2, 4'h1);
		repeat (40) @(posedge clk_i);
		cmp_word(32'(out_count - base), 32'd15);
		end_test("transmit disable");
		// Fill until refused while disabled, then drain against a stalling sink
		wb_write(ADDR_TX_CTRL, 32'h0, 4'hf);
		n = 0;
		tx_in_valid_i <= 1'b1;
		tx_in_data_i  <= rnd();
		tx_in_last_i  <= 1'b0;
		repeat (45) begin
			@(posedge clk_i);
			if (tx_in_ready_o === 1'b1) begin
				tx_q.push_back({tx_in_last_i, tx_in_data_i});
				n++;
				tx_in_data_i <= rnd();
				tx_in_last_i <= (n % 8 == 7) || n == 32;
			end
		end
		tx_in_valid_i <= 1'b0;
		cmp_word(32'(n), 32'd33);
		wb_write(ADDR_TX_CTRL, 32'h2, 4'hf);
		for (int k = 0; k < 300 && tx_q.size() > 0; k++) @(posedge clk_i);
		cmp_word(32'(tx_q.size()), 32'd0);
		end_test("fifo fill and drain");
		// Flush queued words by disabling and resetting
		wb_write(ADDR_TX_CTRL, 32'h0, 4'hf);
		for (int k = 0; k < 3; k++) push_tx(32'(rnd()), k == 2);
		tx_in_valid_i <= 1'b0;
		rst_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		tx_q.delete();
		@(posedge clk_i);
		base = out_count;
		wb_read(ADDR_TX_CTRL, 32'h0);
		wb_write(ADDR_TX_CTRL, 32'h2, 4'hf);
		repeat (20) @(posedge clk_i);
		cmp_word(32'(out_count - base), 32'd0);
		end_test("flush by reset");
		tally_and_finish();
	end
endmodule
